// >>> arr_pkg.sv
package arr_pkg;

  // ==========================================================
  // Result format and timing
  localparam int RES_W = 24;
  localparam int LEAD_CYC = 16;
  localparam logic [4:0] LEAD_LOAD = 5'(LEAD_CYC - 1);
  localparam logic [23:0] RES_POS_FULL = 24'h7F_FFFF;
  localparam logic [23:0] RES_NEG_FULL = 24'h80_0000;
  localparam logic [23:0] RES_RESET = 24'h00_0000;

  // ==========================================================
  // Serial framing
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CMD_READ = 8'h12;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] IDX_NOCRC_LAST = 2'h1;
  localparam logic [1:0] IDX_CRC_BYTE = 2'h2;
  localparam logic [1:0] IDX_CRC_LAST = 2'h3;
  localparam logic [2:0] RESP_LEN_STAT = 3'h4;
  localparam logic [2:0] RESP_LEN_DATA = 3'h3;

  // ==========================================================
  // Status byte layout
  localparam int STAT_NEW_BIT = 0;
  localparam int STAT_CRC_FAIL_FLAG_BIT = 6;

  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    CV_STOP = 4'h1,
    CV_RUN = 4'h2,
    CV_LEAD = 4'h4,
    CV_READY = 4'h8
  } arr_conv_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_CMD = 3'h2,
    PH_RESP = 3'h4
  } arr_phase_t;

endpackage

// >>> arr_crc8_step.sv
`timescale 1ns/1ps
module arr_crc8_step
  import arr_pkg::*;
(
  input wire logic [7:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [7:0] crcOut
);

  // ==========================================================
  // One byte through the CRC-8 divider, most significant bit first
  always_comb begin
    logic [7:0] c;
    logic fb;
    c = crcIn;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ dataIn[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    crcOut = c;
  end

endmodule // arr_crc8_step

// >>> arr_pair_buffer.sv
`timescale 1ns/1ps
module arr_pair_buffer
  import arr_pkg::*;
#(
  parameter int W = 26,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } arr_buf_state_t;

  arr_buf_state_t st_reg;
  arr_buf_state_t st_next;
  logic push;
  logic pop;

  // Ready is registered so the source sees a clean flop output
  assign inReady = st_reg.rdy;
  assign outValid = (st_reg.cnt != '0);
  assign outData = st_reg.mem[st_reg.rp];

  // ==========================================================
  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    push = inValid & st_reg.rdy;
    pop = outReady & (st_reg.cnt != '0);
    if (push) begin
      st_next.mem[st_reg.wp] = inData;
      st_next.wp = (st_reg.wp == LAST_IDX) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == LAST_IDX) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    st_next.rdy = (st_next.cnt != FULL_CNT);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // arr_pair_buffer

// >>> arr_readout_core.sv
// Notes on behaviour
// - Continuous: ready high at start, low on result
// - Continuous: ready returns high after result read
// - Unread result: ready pulses high 16 cycles early
// - Late read gets old data: hold ready edge
// - Late read gets new data: normal edge
// - Pulse mode: ready low until next start
// - New-data bit set when fresh, else cleared
// - Response: status, three data bytes, CRC
// - Status byte only when prefix enable set
// - 24-bit two's complement, sign bit first
// - Zero maps to zero, standard signed coding
// - Overdrive saturates at full-scale codes
// - CRC only when check enable set
// - On CRC match execute, send CRC fourth
// - Reads append CRC over returned payload
// - On mismatch skip, send inverted CRC
// - Mismatch sets fail flag, ready after byte four
// - CRC-8 poly 0x107, preset all ones
// - CRC mode echoes command bytes one, two
// - Mode 1: change on rise, sample fall
// - Pin mirrors ready idle, released when deselected
// - Execute after byte two, or four with CRC
`timescale 1ns/1ps
module arr_readout_core
  import arr_pkg::*;
#(
  parameter int RAW_W = 26,
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic csPinN,
  input wire logic sclkPin,
  input wire logic dinPin,
  output logic serialOutReadyPinO,
  output logic serialOutReadyPinOe,
  input wire logic pulseMode,
  input wire logic statusPrefixEnable,
  input wire logic crcCheckEnable,
  input wire logic convStart,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [RAW_W-1:0] sampleData,
  output logic resultReadyN,
  output logic newDataFlag,
  output logic crcFailFlag,
  input wire logic crcFailClear,
  output logic cmdStrobe,
  output logic [7:0] cmdOpcode,
  output logic [7:0] cmdArg
);

  typedef struct packed {
    logic csS1;
    logic csS2;
    logic sckS1;
    logic sckS2;
    logic sckS3;
    logic dinS1;
    logic dinS2;
    arr_phase_t phase;
    logic [2:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] rxShift;
    logic [7:0] cmdB1;
    logic [7:0] cmdB2;
    logic [7:0] crcRx;
    logic crcOk;
    logic [7:0] txShift;
    logic txBit;
    logic pinO;
    logic pinOe;
    logic [31:0] respData;
    logic [2:0] respLeft;
    logic [7:0] respCrc;
    logic respWithCrc;
    logic respCrcSent;
    arr_conv_t cv;
    logic [4:0] leadCnt;
    logic [RES_W-1:0] nextRes;
    logic [RES_W-1:0] heldRes;
    logic readyN;
    logic newData;
    logic crcFail;
    logic readLock;
    logic cmdStrobe;
    logic [7:0] cmdOpcode;
    logic [7:0] cmdArg;
  } arr_core_state_t;

  arr_core_state_t st_reg;
  arr_core_state_t st_next;

  logic bufValid;
  logic [RAW_W-1:0] bufData;
  logic popNow;
  logic [7:0] cmdCrcIn;
  logic [7:0] cmdCrcOut;
  logic [7:0] respCrcOut;
  logic [7:0] rxByte;
  logic [RAW_W-RES_W:0] rawHigh;
  logic [RES_W-1:0] satRes;
  logic [7:0] crcOutByte;
  logic sckRise;
  logic sckFall;
  logic readDone;
  logic execNow;
  logic execRead;
  logic crcMismatch;
  logic lockNow;
  logic inLead;

  // ==========================================================
  // Sample path: stalls the filter while a result waits to publish
  arr_pair_buffer #(
    .W(RAW_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(bufValid),
    .outReady(popNow),
    .outData(bufData)
  );

  // Command CRC runs per received byte, response CRC per sent byte
  arr_crc8_step u_cmd_crc (
    .crcIn(cmdCrcIn),
    .dataIn(rxByte),
    .crcOut(cmdCrcOut)
  );

  arr_crc8_step u_resp_crc (
    .crcIn(st_reg.respCrc),
    .dataIn(st_reg.respData[31:24]),
    .crcOut(respCrcOut)
  );

  // ==========================================================
  // Saturation: a wrap would turn overdrive into the wrong sign
  assign rawHigh = bufData[RAW_W-1:RES_W-1];
  always_comb begin
    if ((&rawHigh) || !(|rawHigh)) begin
      satRes = bufData[RES_W-1:0];
    end else if (bufData[RAW_W-1]) begin
      satRes = RES_NEG_FULL;
    end else begin
      satRes = RES_POS_FULL;
    end
  end

  assign rxByte = {st_reg.rxShift[6:0], st_reg.dinS2};
  assign cmdCrcIn = (st_reg.byteIdx == 2'h0) ? CRC_INIT : st_reg.crcRx;
  assign crcOutByte = st_reg.crcOk ? st_reg.crcRx : ~st_reg.crcRx;
  assign sckRise = st_reg.sckS2 & ~st_reg.sckS3;
  assign sckFall = ~st_reg.sckS2 & st_reg.sckS3;
  assign inLead = (st_reg.cv == CV_LEAD);

  // ==========================================================
  // Next-state logic: serial frame, then conversion and ready
  always_comb begin
    logic [7:0] byteOut;
    logic [7:0] stat;
    logic bitOut;
    st_next = st_reg;
    byteOut = IDLE_BYTE;
    stat = 8'h00;
    bitOut = st_reg.txBit;
    popNow = 1'b0;
    readDone = 1'b0;
    execNow = 1'b0;
    execRead = 1'b0;
    crcMismatch = 1'b0;
    st_next.csS1 = csPinN;
    st_next.csS2 = st_reg.csS1;
    st_next.sckS1 = sclkPin;
    st_next.sckS2 = st_reg.sckS1;
    st_next.sckS3 = st_reg.sckS2;
    st_next.dinS1 = dinPin;
    st_next.dinS2 = st_reg.dinS1;
    st_next.cmdStrobe = 1'b0;
    stat[STAT_NEW_BIT] = st_reg.newData;
    stat[STAT_CRC_FAIL_FLAG_BIT] = st_reg.crcFail;
    if (crcFailClear) begin
      st_next.crcFail = 1'b0;
    end

    if (st_reg.csS2) begin
      // Deselect aborts the frame; an open response counts as read
      readDone = (st_reg.phase == PH_RESP);
      st_next.phase = PH_IDLE;
      st_next.bitCnt = 3'h0;
      st_next.byteIdx = 2'h0;
    end else begin
      // Output changes on the rising edge only
      if (sckRise) begin
        if (st_reg.bitCnt == 3'h0) begin
          unique case (st_reg.phase)
            PH_IDLE: begin
              st_next.phase = PH_CMD;
              byteOut = IDLE_BYTE;
            end
            PH_CMD: begin
              if (st_reg.byteIdx == 2'h1) begin
                byteOut = st_reg.cmdB1;
              end else if (st_reg.byteIdx == IDX_CRC_BYTE) begin
                byteOut = st_reg.cmdB2;
              end else if (st_reg.byteIdx == IDX_CRC_LAST) begin
                byteOut = crcOutByte;
              end else begin
                byteOut = IDLE_BYTE;
              end
            end
            PH_RESP: begin
              if (st_reg.respLeft != 3'h0) begin
                byteOut = st_reg.respData[31:24];
                st_next.respData = {st_reg.respData[23:0], 8'h00};
                st_next.respLeft = st_reg.respLeft - 3'h1;
                st_next.respCrc = respCrcOut;
              end else begin
                byteOut = st_reg.respCrc;
                st_next.respCrcSent = 1'b1;
              end
            end
          endcase
          bitOut = byteOut[7];
          st_next.txShift = {byteOut[6:0], 1'b0};
        end else begin
          bitOut = st_reg.txShift[7];
          st_next.txShift = {st_reg.txShift[6:0], 1'b0};
        end
        st_next.txBit = bitOut;
      end

      // Input is taken on the falling edge
      if (sckFall && st_reg.phase != PH_IDLE) begin
        st_next.rxShift = rxByte;
        st_next.bitCnt = st_reg.bitCnt + 3'h1;
        if (st_reg.bitCnt == BIT_LAST && st_reg.phase == PH_CMD) begin
          st_next.byteIdx = st_reg.byteIdx + 2'h1;
          unique case (st_reg.byteIdx)
            2'h0: begin
              st_next.cmdB1 = rxByte;
              st_next.crcRx = cmdCrcOut;
            end
            IDX_NOCRC_LAST: begin
              st_next.cmdB2 = rxByte;
              st_next.crcRx = cmdCrcOut;
              execNow = !crcCheckEnable;
            end
            IDX_CRC_BYTE: begin
              st_next.crcOk = (rxByte == st_reg.crcRx);
            end
            IDX_CRC_LAST: begin
              execNow = st_reg.crcOk;
              crcMismatch = !st_reg.crcOk;
              st_next.phase = PH_IDLE;
              st_next.byteIdx = 2'h0;
            end
          endcase
        end else if (st_reg.bitCnt == BIT_LAST) begin
          // Response ends after the last payload or its CRC
          if (st_reg.respLeft == 3'h0 &&
              (!st_reg.respWithCrc || st_reg.respCrcSent)) begin
            readDone = 1'b1;
            st_next.phase = PH_IDLE;
            st_next.byteIdx = 2'h0;
          end
        end
      end
    end

    if (crcMismatch) begin
      st_next.crcFail = 1'b1;
    end

    // Command execution; the read snapshots the held result
    if (execNow) begin
      st_next.cmdStrobe = 1'b1;
      st_next.cmdOpcode = st_reg.cmdB1;
      st_next.cmdArg = crcCheckEnable ? st_reg.cmdB2 : rxByte;
      st_next.phase = PH_IDLE;
      st_next.byteIdx = 2'h0;
      if (st_reg.cmdB1 == CMD_READ) begin
        execRead = 1'b1;
        st_next.phase = PH_RESP;
        st_next.readLock = 1'b1;
        st_next.respCrc = CRC_INIT;
        st_next.respWithCrc = crcCheckEnable;
        st_next.respCrcSent = 1'b0;
        if (statusPrefixEnable) begin
          st_next.respData = {stat, st_reg.heldRes};
          st_next.respLeft = RESP_LEN_STAT;
        end else begin
          st_next.respData = {st_reg.heldRes, 8'h00};
          st_next.respLeft = RESP_LEN_DATA;
        end
      end
    end

    // A read in flight pins the old result in place
    lockNow = st_reg.readLock | execRead;
    if (readDone) begin
      st_next.readLock = 1'b0;
      st_next.newData = 1'b0;
      if (!pulseMode && st_reg.cv == CV_READY) begin
        st_next.readyN = 1'b1;
      end
    end

    // ==========================================================
    // Conversion sequencing and the ready output
    if (convStart) begin
      st_next.cv = CV_RUN;
      st_next.readyN = 1'b1;
    end else begin
      unique case (st_reg.cv)
        CV_STOP: begin
        end
        CV_RUN: begin
          if (bufValid) begin
            popNow = 1'b1;
            st_next.nextRes = satRes;
            st_next.leadCnt = LEAD_LOAD;
            st_next.cv = CV_LEAD;
          end
        end
        CV_LEAD: begin
          if (st_reg.leadCnt != 5'h00) begin
            st_next.leadCnt = st_reg.leadCnt - 5'h01;
          end else if (!lockNow) begin
            st_next.heldRes = st_reg.nextRes;
            st_next.newData = 1'b1;
            st_next.readyN = 1'b0;
            st_next.cv = CV_READY;
          end
        end
        CV_READY: begin
          // Pulse mode holds until a new start; continuous moves on
          if (!pulseMode && bufValid) begin
            popNow = 1'b1;
            st_next.nextRes = satRes;
            st_next.leadCnt = LEAD_LOAD;
            st_next.readyN = 1'b1;
            st_next.cv = CV_LEAD;
          end
        end
      endcase
    end

    // Pin: released when deselected, data in a frame, else ready
    if (st_reg.csS2) begin
      st_next.pinO = 1'b1;
      st_next.pinOe = 1'b1;
    end else if (st_next.phase != PH_IDLE) begin
      st_next.pinO = st_next.txBit;
      st_next.pinOe = 1'b0;
    end else begin
      st_next.pinO = st_reg.readyN;
      st_next.pinOe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.csS1 <= 1'b1;
      st_reg.csS2 <= 1'b1;
      st_reg.phase <= PH_IDLE;
      st_reg.cv <= CV_STOP;
      st_reg.readyN <= 1'b1;
      st_reg.pinO <= 1'b1;
      st_reg.pinOe <= 1'b1;
      st_reg.respCrc <= CRC_INIT;
      st_reg.heldRes <= RES_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serialOutReadyPinO = st_reg.pinO;
  assign serialOutReadyPinOe = st_reg.pinOe;
  assign resultReadyN = st_reg.readyN;
  assign newDataFlag = st_reg.newData;
  assign crcFailFlag = st_reg.crcFail;
  assign cmdStrobe = st_reg.cmdStrobe;
  assign cmdOpcode = st_reg.cmdOpcode;
  assign cmdArg = st_reg.cmdArg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence sLeadEnter;
    $rose(inLead);
  endsequence

  sequence sLeadHold;
    inLead [*8] ##1 inLead [*8];
  endsequence

  chk_lead_span_len: assert property (
    disable iff (rst || convStart) sLeadEnter |-> sLeadHold)
    else $error("lead interval shorter than 16 cycles");

  chk_publish_drop: assert property (
    (inLead && st_reg.leadCnt == 5'h00 && !lockNow && !convStart)
    |=> (!resultReadyN && newDataFlag))
    else $error("result not published at end of lead");

  chk_late_read_hold: assert property (
    (inLead && st_reg.leadCnt == 5'h00 && lockNow && !convStart)
    |=> (resultReadyN && inLead))
    else $error("ready fell during an old-data read");

  chk_read_ready_up: assert property (
    (readDone && !pulseMode && st_reg.cv == CV_READY && !convStart)
    |=> resultReadyN)
    else $error("ready not raised after read");

  chk_pulse_ready_hold: assert property (
    (pulseMode && st_reg.cv == CV_READY && !resultReadyN && !convStart)
    |=> !resultReadyN)
    else $error("pulse mode ready left low state");

  chk_read_clr_new: assert property (
    readDone |=> !newDataFlag)
    else $error("new-data bit survived a read");

  chk_crc_fail_set: assert property (
    crcMismatch |=> (crcFailFlag && st_reg.phase == PH_IDLE))
    else $error("crc error not flagged");

  chk_exec_point_byte: assert property (
    cmdStrobe |-> ($past(crcCheckEnable)
      ? ($past(st_reg.byteIdx) == IDX_CRC_LAST)
      : ($past(st_reg.byteIdx) == IDX_NOCRC_LAST)))
    else $error("command executed at wrong byte");

  chk_pin_release: assert property (
    st_reg.csS2 |=> (serialOutReadyPinOe && serialOutReadyPinO))
    else $error("pin driven while deselected");

  chk_sat_positive: assert property (
    (popNow && !bufData[RAW_W-1] && (|rawHigh))
    |=> st_reg.nextRes == RES_POS_FULL)
    else $error("positive overdrive not clipped");

endmodule // arr_readout_core

// >>> arr_host_model.sv
`timescale 1ns/1ps
// ====================
// Host controller on the serial link
module arr_host_model
  import arr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pinLevel,
  output logic csPinN,
  output logic sclkPin,
  output logic dinPin
);
  // Bus idles deselected with the clock low
  initial begin
    csPinN = 1'b1;
    sclkPin = 1'b0;
    dinPin = 1'b0;
  end

  // Gap after select lets the device synchronisers catch up
  task automatic sel(input logic lvl);
    @(negedge sys_clk) csPinN = lvl;
    repeat (8) @(negedge sys_clk);
  endtask

  // One byte MSB first, 32 ns clock period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk) sclkPin = 1'b1;
      dinPin = tx[i];
      repeat (3) @(negedge sys_clk);
      @(negedge sys_clk) rx[i] = pinLevel;
      sclkPin = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    dinPin = ~dinPin;
    repeat (8) @(negedge sys_clk);
  endtask

  // Bitwise CRC step; preset and final value left to the caller
  function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endmodule // arr_host_model

// >>> tb.sv
`timescale 1ns/1ps
module tb
  import arr_pkg::*;
;
  logic sys_clk, rst, csPinN, sclkPin, dinPin, pinO, pinOe, pinLevel;
  logic lastPin, pulseMode, statEn, crcEn, convStart, sampleValid;
  logic sampleReady, resultReadyN, newDataFlag, crcFailFlag;
  logic crcFailClear, cmdStrobe;
  logic [25:0] sampleData;
  logic [7:0] cmdOpcode, cmdArg;
  int n_fail = 0;
  int cmp_count = 0;
  int nStrobe = 0;

  // ====================
  // Clock, pin model and strobe count
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  // A released pin shows the inverse of its last level, never a copy
  always @(posedge sys_clk) if (!pinOe) lastPin <= pinO;
  assign pinLevel = pinOe ? ~lastPin : pinO;
  always @(posedge sys_clk) if (cmdStrobe === 1'b1) nStrobe++;

  arr_readout_core u_dut (
    .sys_clk(sys_clk), .rst(rst), .csPinN(csPinN), .sclkPin(sclkPin),
    .dinPin(dinPin), .serialOutReadyPinO(pinO),
    .serialOutReadyPinOe(pinOe), .pulseMode(pulseMode),
    .statusPrefixEnable(statEn), .crcCheckEnable(crcEn),
    .convStart(convStart), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData),
    .resultReadyN(resultReadyN), .newDataFlag(newDataFlag),
    .crcFailFlag(crcFailFlag), .crcFailClear(crcFailClear),
    .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode), .cmdArg(cmdArg)
  );

  arr_host_model u_host (
    .sys_clk(sys_clk), .pinLevel(pinLevel), .csPinN(csPinN),
    .sclkPin(sclkPin), .dinPin(dinPin)
  );

  // ====================
  // Compare and closing tasks
  task automatic chkVal(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    chkVal({16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkVal({23'h00_0000, got}, {23'h00_0000, exp});
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====================
  // Stimulus helpers
  task automatic pushSample(input logic [25:0] d);
    @(negedge sys_clk) sampleValid = 1'b1;
    sampleData = d;
    while (sampleReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk) sampleValid = 1'b0;
  endtask
  task automatic setCfg(input logic pm, input logic se, input logic ce);
    @(negedge sys_clk) pulseMode = pm;
    statEn = se;
    crcEn = ce;
  endtask
  task automatic pulseStart();
    @(negedge sys_clk) convStart = 1'b1;
    @(negedge sys_clk) convStart = 1'b0;
    chkBit(resultReadyN, 1'b1);
  endtask
  // Host waits for ready so the read never races the next result
  task automatic waitLow();
    int n;
    n = 0;
    while (resultReadyN !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chkBit(resultReadyN, 1'b0);
  endtask
  task automatic readData(input logic crcOn, input logic stOn,
      output logic [7:0] st, output logic [23:0] d);
    logic [7:0] r;
    logic [7:0] c;
    c = u_host.crc8(u_host.crc8(CRC_INIT, CMD_READ), 8'h00);
    st = 8'h00;
    d = 24'h00_0000;
    u_host.sel(1'b0);
    u_host.xfer(CMD_READ, r);
    chkByte(r, IDLE_BYTE);
    u_host.xfer(8'h00, r);
    chkByte(r, CMD_READ);
    if (crcOn) begin
      u_host.xfer(c, r);
      chkByte(r, 8'h00);
      u_host.xfer(8'h00, r);
      chkByte(r, c);
    end
    c = CRC_INIT;
    if (stOn) begin
      u_host.xfer(8'h00, st);
      c = u_host.crc8(c, st);
    end
    repeat (3) begin
      u_host.xfer(8'h00, r);
      d = {d[15:0], r};
      c = u_host.crc8(c, r);
    end
    if (crcOn) begin
      u_host.xfer(8'h00, r);
      chkByte(r, c);
    end
    u_host.sel(1'b1);
  endtask

  // ====================
  // Scenarios
  task automatic runCont();
    logic [7:0] st;
    logic [23:0] d;
    int n;
    pulseStart();
    pushSample(26'h000_0001);
    waitLow();
    u_host.sel(1'b0);
    chkBit(pinO, resultReadyN);
    chkBit(pinOe, 1'b0);
    u_host.sel(1'b1);
    chkBit(pinOe, 1'b1);
    pushSample(26'h3FF_FFFF);
    n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (resultReadyN === 1'b1) n++;
    end
    chkVal(24'(n), 24'(LEAD_CYC));
    readData(1'b0, 1'b0, st, d);
    chkVal(d, 24'hFF_FFFF);
    repeat (3) @(negedge sys_clk);
    chkBit(resultReadyN, 1'b1);
  endtask
  task automatic runSat();
    logic [7:0] st;
    logic [23:0] d;
    setCfg(1'b0, 1'b1, 1'b0);
    pushSample(26'h1FF_FFFF);
    waitLow();
    readData(1'b0, 1'b1, st, d);
    chkBit(st[STAT_NEW_BIT], 1'b1);
    chkVal(d, RES_POS_FULL);
    readData(1'b0, 1'b1, st, d);
    chkBit(st[STAT_NEW_BIT], 1'b0);
    chkVal(d, RES_POS_FULL);
    setCfg(1'b0, 1'b0, 1'b0);
    pushSample(26'h200_0000);
    waitLow();
    readData(1'b0, 1'b0, st, d);
    chkVal(d, RES_NEG_FULL);
  endtask
  // Reads that race the next result: first old data, then fresh data
  task automatic runLate();
    logic [7:0] st;
    logic [23:0] d;
    setCfg(1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      fork
        readData(1'b0, 1'b1, st, d);
        begin
          repeat ((k == 0) ? 134 : 116) @(negedge sys_clk);
          pushSample((k == 0) ? 26'h000_0100 : 26'h000_0200);
          repeat (30) @(negedge sys_clk);
          chkBit(resultReadyN, 1'(k == 0));
        end
      join
      chkVal(d, (k == 0) ? RES_NEG_FULL : 24'h00_0200);
      chkBit(st[STAT_NEW_BIT], 1'(k != 0));
      chkBit(resultReadyN, 1'(k != 0));
      chkBit(newDataFlag, 1'(k == 0));
    end
  endtask
  task automatic runCrc();
    logic [7:0] st;
    logic [23:0] d;
    setCfg(1'b0, 1'b1, 1'b1);
    pushSample(26'h000_1234);
    waitLow();
    readData(1'b1, 1'b1, st, d);
    chkVal(d, 24'h00_1234);
    chkBit(st[STAT_NEW_BIT], 1'b1);
  endtask
  // Bad frame then good frame under one select
  task automatic runBad();
    logic [7:0] r, c, e;
    int m;
    m = nStrobe;
    c = u_host.crc8(u_host.crc8(CRC_INIT, 8'h08), 8'h5A);
    u_host.sel(1'b0);
    for (int k = 0; k < 2; k++) begin
      e = (k == 0) ? ~c : c;
      u_host.xfer(8'h08, r);
      u_host.xfer(8'h5A, r);
      u_host.xfer(c ^ 8'(k == 0), r);
      u_host.xfer(8'h00, r);
      chkByte(r, e);
      chkByte(cmdOpcode, (k == 0) ? CMD_READ : 8'h08);
      chkBit(crcFailFlag, 1'b1);
    end
    u_host.sel(1'b1);
    chkByte(cmdArg, 8'h5A);
    chkVal(24'(nStrobe - m), 24'h00_0001);
    @(negedge sys_clk) crcFailClear = 1'b1;
    @(negedge sys_clk) crcFailClear = 1'b0;
    chkBit(crcFailFlag, 1'b0);
  endtask
  // Buffer fills while single-shot results wait, then drains
  task automatic runPulse();
    logic [7:0] st;
    logic [23:0] d;
    setCfg(1'b1, 1'b0, 1'b0);
    pulseStart();
    pushSample(26'h000_0005);
    pushSample(26'h000_0006);
    pushSample(26'h000_0007);
    @(negedge sys_clk) sampleValid = 1'b1;
    sampleData = 26'h000_0008;
    repeat (4) @(negedge sys_clk);
    chkBit(sampleReady, 1'b0);
    waitLow();
    readData(1'b0, 1'b0, st, d);
    chkVal(d, 24'h00_0005);
    chkBit(resultReadyN, 1'b0);
    for (int k = 6; k < 9; k++) begin
      pulseStart();
      if (k == 6) begin
        while (sampleReady !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk) sampleValid = 1'b0;
      end
      waitLow();
      readData(1'b0, 1'b0, st, d);
      chkVal(d, 24'(k));
    end
  endtask

  // ====================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    lastPin = 1'b0;
    {pulseMode, statEn, crcEn, convStart, sampleValid} = 5'h00;
    crcFailClear = 1'b0;
    sampleData = 26'h000_0000;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chkBit(pinOe, 1'b1);
    runCont();
    runSat();
    runLate();
    runCrc();
    runBad();
    runPulse();
    wrap_up();
  end
  // Tests need roughly six thousand cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
endmodule // tb
